// >>> hw/acp_chain.sv
// converter chain scheduler: preemption, restore, end events, axi4-lite registers
//
// Contract
// - injected chain aborts and preempts normal chain
// - trigger unit preempts normal or injected chain
// - aborted channel restored and converted again
// - completion marks result valid, sets pending flag
// - trigger in last sampling: two end events
// - scan, trigger in last conversion: no second
// - one-shot, last conversion abort restarts chain
// - running flag stays while another event follows
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
module acp_chain #(
    parameter int NCH = acp_pkg::NCH_DEF,
    parameter int DW  = acp_pkg::DW_DEF
) (
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // axi4-lite write
    input  wire logic [acp_pkg::AW-1:0] awaddr,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    // axi4-lite read
    input  wire logic [acp_pkg::AW-1:0] araddr,
    input  wire logic                   arvalid,
    output logic                        arready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,
    // cross trigger unit pins
    input  wire logic                   ctu_trig,
    input  wire logic [$clog2(NCH)-1:0] ctu_ch,
    // analogue sample and convert stage
    output logic                        conv_start,
    output logic                        conv_abort,
    output logic [$clog2(NCH)-1:0]      conv_ch,
    input  wire logic                   samp_done,
    input  wire logic                   conv_done,
    input  wire logic [DW-1:0]          conv_data,
    // interrupt
    output logic                        irq
);
    localparam int CW = $clog2(NCH);

    // lowest set mask bit at or above from; top bit flags found
    function automatic logic [CW:0] nxt_ch(input logic [NCH-1:0] m, input logic [CW:0] from);
        logic [CW:0] r;
        r = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (m[i] && i >= int'(from)) begin
                r = {1'b1, CW'(i)};
            end
        end
        return r;
    endfunction

    acp_pkg::acp_state_t st_ff;
    logic [1:0]              kind_ff;
    logic [CW-1:0]           ch_ff;
    logic [NCH-1:0]          mask_ff [2];
    logic [CW-1:0]           idx_ff [2];
    logic [1:0]              run_ff;
    logic [1:0]              supp_ff;
    logic                    scan_ff;
    logic                    ctu_pend_ff;
    logic [CW-1:0]           ctu_ch_ff;
    logic                    trig_d_ff;
    logic [DW-1:0]           res_ff [NCH];
    logic [acp_pkg::EV_W-1:0] ev_mask_ff;
    logic                    aw_got_ff;
    logic                    w_got_ff;
    logic [acp_pkg::AW-1:0]  awaddr_ff;
    logic [31:0]             wdata_ff;
    logic [3:0]              wstrb_ff;

    logic [CW:0]             sync_q;
    logic [CW:0]             nx;
    logic [CW:0]             fst [2];
    logic                    k;
    logic                    in_chain;
    logic                    last;
    logic                    busy;
    logic                    done;
    logic                    scan_k;
    logic                    preempt;
    logic                    trig_edge;
    logic [acp_pkg::EV_W-1:0] ev_set;
    logic [acp_pkg::EV_W-1:0] ev_q;
    logic [NCH-1:0]          done_vec;
    logic [NCH-1:0]          pend_q;
    logic [NCH-1:0]          pend_clr;
    logic [NCH-1:0]          vld_q;
    logic [NCH-1:0]          vld_clr;
    logic [31:0]             wm;
    logic [31:0]             wd_m;
    logic                    wr_en;
    logic                    wr_ok;
    logic [1:0]              start_req;
    logic                    res_hit;
    logic [CW-1:0]           rd_idx;
    logic [31:0]             rd_val;
    logic                    rd_ok;
    logic [1:0]              pick_k;
    logic [CW-1:0]           pick_ch;

    // trigger level and channel cross from the pin domain together
    acp_sync #(.W(CW + 1)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({ctu_trig, ctu_ch}),
        .q       (sync_q)
    );

    // scheduler decisions for the channel in flight
    always_comb begin
        k         = kind_ff[0];
        in_chain  = (kind_ff != acp_pkg::K_CTU);
        nx        = nxt_ch(mask_ff[k], {1'b0, idx_ff[k]} + 1'b1);
        last      = !nx[CW];
        busy      = (st_ff != acp_pkg::ST_IDLE);
        done      = (st_ff == acp_pkg::ST_CONV) && conv_done;
        scan_k    = scan_ff && (kind_ff == acp_pkg::K_NORM);
        // trigger unit first, then injected, then normal
        pick_k    = ctu_pend_ff ? acp_pkg::K_CTU : (run_ff[1] ? acp_pkg::K_INJ : acp_pkg::K_NORM);
        pick_ch   = ctu_pend_ff ? ctu_ch_ff : idx_ff[pick_k[0]];
        // a finishing conversion is never thrown away
        preempt   = busy && !done &&
                    ((ctu_pend_ff && in_chain) ||
                     (run_ff[1] && kind_ff == acp_pkg::K_NORM));
        trig_edge = sync_q[CW] && !trig_d_ff;
        done_vec  = '0;
        if (done) begin
            done_vec[ch_ff] = 1'b1;
        end
        for (int c = 0; c < 2; c++) begin
            fst[c] = nxt_ch(mask_ff[c], '0);
        end
    end

    // end events; preempting the last channel while sampling, or in scan mode, raises one early
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            ev_set[c] = in_chain && (k == 1'(c)) && last &&
                        ((preempt && (st_ff == acp_pkg::ST_SAMP || scan_k)) ||
                         (done && !supp_ff[c]));
        end
        ev_set[acp_pkg::EV_C] = done && !in_chain;
    end

    // conversion sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff      <= acp_pkg::ST_IDLE;
            kind_ff    <= acp_pkg::K_NORM;
            ch_ff      <= '0;
            conv_start <= 1'b0;
            conv_abort <= 1'b0;
            conv_ch    <= '0;
        end else begin
            conv_start <= 1'b0;
            conv_abort <= 1'b0;
            case (st_ff)
                acp_pkg::ST_IDLE: begin
                    if (ctu_pend_ff || |run_ff) begin
                        kind_ff    <= pick_k;
                        ch_ff      <= pick_ch;
                        conv_ch    <= pick_ch;
                        conv_start <= 1'b1;
                        st_ff      <= acp_pkg::ST_SAMP;
                    end
                end
                acp_pkg::ST_SAMP: begin
                    if (preempt) begin
                        conv_abort <= 1'b1;
                        st_ff      <= acp_pkg::ST_IDLE;
                    end else if (samp_done) begin
                        st_ff <= acp_pkg::ST_CONV;
                    end
                end
                acp_pkg::ST_CONV: begin
                    if (done) begin
                        st_ff <= acp_pkg::ST_IDLE;
                    end else if (preempt) begin
                        conv_abort <= 1'b1;
                        st_ff      <= acp_pkg::ST_IDLE;
                    end
                end
                default: begin
                    st_ff <= acp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // chain position; an abort leaves the index alone, so it is restored, except a one-shot last-conversion abort, which goes back to the first channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_ff  <= '0;
            supp_ff <= '0;
            idx_ff  <= '{default: '0};
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (start_req[c] && !run_ff[c] && |mask_ff[c]) begin
                    run_ff[c]  <= 1'b1;
                    supp_ff[c] <= 1'b0;
                    idx_ff[c]  <= fst[c][CW-1:0];
                end
            end
            if (in_chain && preempt && last && st_ff == acp_pkg::ST_CONV) begin
                if (scan_k) begin
                    supp_ff[k] <= 1'b1;
                end else begin
                    idx_ff[k] <= fst[k][CW-1:0];
                end
            end
            if (in_chain && done) begin
                if (!last) begin
                    idx_ff[k] <= nx[CW-1:0];
                end else begin
                    supp_ff[k] <= 1'b0;
                    if (scan_k) begin
                        idx_ff[k] <= fst[k][CW-1:0];
                    end else begin
                        run_ff[k] <= 1'b0;
                    end
                end
            end
        end
    end

    // trigger unit request, a new edge beats the clear of the old one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_d_ff   <= 1'b0;
            ctu_pend_ff <= 1'b0;
            ctu_ch_ff   <= '0;
        end else begin
            trig_d_ff <= sync_q[CW];
            if (trig_edge) begin
                ctu_pend_ff <= 1'b1;
                ctu_ch_ff   <= sync_q[CW-1:0];
            end else if (done && !in_chain) begin
                ctu_pend_ff <= 1'b0;
            end
        end
    end

    // result words, zero until converted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_ff <= '{default: '0};
        end else if (done) begin
            res_ff[ch_ff] <= conv_data;
        end
    end

    acp_ev #(.W(NCH)) u_pend (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (done_vec),
        .clr     (pend_clr),
        .q       (pend_q)
    );

    acp_ev #(.W(NCH)) u_vld (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (done_vec),
        .clr     (vld_clr),
        .q       (vld_q)
    );

    acp_ev #(.W(acp_pkg::EV_W)) u_ev (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (ev_set),
        .clr     (wr_en && awaddr_ff == acp_pkg::OFF_EV_STAT ?
                  wd_m[acp_pkg::EV_W-1:0] : '0),
        .q       (ev_q)
    );

    // register write decode
    always_comb begin
        wm        = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
        wd_m      = wdata_ff & wm;
        wr_en     = aw_got_ff && w_got_ff && !bvalid;
        // writable words are the aligned ones up to the mask, status excepted
        wr_ok     = (awaddr_ff <= acp_pkg::OFF_EV_MASK) && (awaddr_ff[1:0] == 2'h0) &&
                    (awaddr_ff != acp_pkg::OFF_STAT);
        start_req = '0;
        pend_clr  = '0;
        if (wr_en && awaddr_ff == acp_pkg::OFF_CTRL) begin
            start_req = {wd_m[acp_pkg::CTRL_INJECTED_CHAIN_RUNNING], wd_m[acp_pkg::CTRL_NORMAL_CHAIN_RUNNING]};
        end
        if (wr_en && awaddr_ff == acp_pkg::OFF_PEND) begin
            pend_clr = wd_m[NCH-1:0];
        end
    end

    // software settings
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scan_ff    <= 1'b0;
            mask_ff    <= '{default: '0};
            ev_mask_ff <= '0;
        end else if (wr_en) begin
            case (awaddr_ff)
                acp_pkg::OFF_CTRL: begin
                    if (wstrb_ff[0]) begin
                        scan_ff <= wdata_ff[acp_pkg::CTRL_SCAN];
                    end
                end
                acp_pkg::OFF_NMASK: begin
                    mask_ff[0] <= (mask_ff[0] & ~wm[NCH-1:0]) | wd_m[NCH-1:0];
                end
                acp_pkg::OFF_JMASK: begin
                    mask_ff[1] <= (mask_ff[1] & ~wm[NCH-1:0]) | wd_m[NCH-1:0];
                end
                acp_pkg::OFF_EV_MASK: begin
                    if (wstrb_ff[0]) begin
                        ev_mask_ff <= wdata_ff[acp_pkg::EV_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(ev_q & ev_mask_ff);
        end
    end

    // read decode; a result read consumes its valid bit
    always_comb begin
        res_hit = (araddr[acp_pkg::AW-1:2] >= acp_pkg::OFF_RES[acp_pkg::AW-1:2]) &&
                  (araddr[acp_pkg::AW-1:2] <
                   acp_pkg::OFF_RES[acp_pkg::AW-1:2] + (acp_pkg::AW - 2)'(NCH));
        rd_idx  = CW'(araddr[acp_pkg::AW-1:2] - acp_pkg::OFF_RES[acp_pkg::AW-1:2]);
        rd_val  = '0;
        rd_ok   = 1'b1;
        vld_clr = '0;
        case (araddr)
            acp_pkg::OFF_CTRL:    rd_val[acp_pkg::CTRL_SCAN] = scan_ff;
            acp_pkg::OFF_NMASK:   rd_val[NCH-1:0] = mask_ff[0];
            acp_pkg::OFF_JMASK:   rd_val[NCH-1:0] = mask_ff[1];
            acp_pkg::OFF_STAT: begin
                rd_val[acp_pkg::STAT_NRUN] = run_ff[0];
                rd_val[acp_pkg::STAT_JRUN] = run_ff[1];
                rd_val[acp_pkg::STAT_CTU]  = ctu_pend_ff;
                rd_val[acp_pkg::STAT_ST +: 3] = st_ff;
            end
            acp_pkg::OFF_PEND:    rd_val[NCH-1:0] = pend_q;
            acp_pkg::OFF_EV_STAT: rd_val[acp_pkg::EV_W-1:0] = ev_q;
            acp_pkg::OFF_EV_MASK: rd_val[acp_pkg::EV_W-1:0] = ev_mask_ff;
            default: begin
                if (res_hit && araddr[1:0] == 2'h0) begin
                    rd_val[DW-1:0]          = res_ff[rd_idx];
                    rd_val[acp_pkg::RES_VLD] = vld_q[rd_idx];
                    if (arvalid && arready) begin
                        vld_clr[rd_idx] = 1'b1;
                    end
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    // axi4-lite write channels, address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready   <= 1'b1;
            wready    <= 1'b1;
            bvalid    <= 1'b0;
            bresp     <= acp_pkg::RESP_OKAY;
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff  <= '0;
            wstrb_ff  <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= awaddr;
                awready   <= 1'b0;
            end
            if (wvalid && wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
                wready   <= 1'b0;
            end
            if (wr_en) begin
                bvalid    <= 1'b1;
                bresp     <= wr_ok ? acp_pkg::RESP_OKAY : acp_pkg::RESP_SLVERR;
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // axi4-lite read channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= acp_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_val;
            rresp   <= rd_ok ? acp_pkg::RESP_OKAY : acp_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic          rst_chk_ff;
    logic          rst_k_ff;
    logic [CW-1:0] rst_ch_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_chk_ff <= 1'b0;
            rst_k_ff   <= 1'b0;
            rst_ch_ff  <= '0;
        end else if (preempt && in_chain && !(st_ff == acp_pkg::ST_CONV && last && !scan_k)) begin
            rst_chk_ff <= 1'b1;
            rst_k_ff   <= k;
            rst_ch_ff  <= ch_ff;
        end else if (conv_start && kind_ff == {1'b0, rst_k_ff}) begin
            rst_chk_ff <= 1'b0;
        end
    end

    a_inj_over_norm: assert property (busy && kind_ff == acp_pkg::K_NORM && run_ff[1] && !done
        |=> conv_abort && st_ff == acp_pkg::ST_IDLE) else $error("normal not preempted");
    a_ctu_over_chain: assert property (busy && in_chain && ctu_pend_ff && !done
        |=> conv_abort ##1 conv_start && kind_ff == acp_pkg::K_CTU)
        else $error("trigger did not preempt");
    a_restore_same_ch: assert property (rst_chk_ff && conv_start && kind_ff == {1'b0, rst_k_ff}
        |-> ch_ff == rst_ch_ff) else $error("aborted channel not restored");
    a_done_marks: assert property (done
        |=> pend_q[$past(ch_ff)] && vld_q[$past(ch_ff)]) else $error("completion not flagged");
    a_samp_last_ev: assert property (preempt && kind_ff == acp_pkg::K_NORM && last &&
        st_ff == acp_pkg::ST_SAMP |=> ev_q[acp_pkg::EV_N] && run_ff[0])
        else $error("early end event missing");
    a_scan_no_second: assert property (preempt && kind_ff == acp_pkg::K_NORM && last &&
        st_ff == acp_pkg::ST_CONV && scan_ff |=> supp_ff[0] && ev_q[acp_pkg::EV_N])
        else $error("scan abort handling wrong");
    a_oneshot_restart: assert property (preempt && kind_ff == acp_pkg::K_NORM && last &&
        st_ff == acp_pkg::ST_CONV && !scan_ff && !ev_q[acp_pkg::EV_N]
        |=> run_ff[0] && idx_ff[0] == $past(fst[0][CW-1:0]) && !ev_q[acp_pkg::EV_N])
        else $error("one-shot chain not restarted");
    a_run_held: assert property (ev_set[acp_pkg::EV_N] && !(done && !scan_ff)
        |=> run_ff[0]) else $error("running flag dropped early");

    c_inj_preempt: cover property (preempt && kind_ff == acp_pkg::K_NORM && run_ff[1]);
    c_early_end: cover property (ev_set[acp_pkg::EV_N] && preempt);
    c_ctu_done: cover property (done && kind_ff == acp_pkg::K_CTU);
endmodule

// >>> hw/acp_ev.sv
// sticky flag vector, a set in the same cycle as a clear wins
`timescale 1ns/1ps
module acp_ev #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // set and clear
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] q
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= set | (q & ~clr);
        end
    end
endmodule

// >>> hw/acp_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module acp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule

// >>> include/acp_pkg.sv
// package: register map, fields, encodings and states
package acp_pkg;
    localparam int NCH_DEF = 8;
    localparam int DW_DEF  = 12;
    localparam int AW      = 8;

    // register byte offsets
    localparam logic [AW-1:0] OFF_CTRL    = 8'h00;
    localparam logic [AW-1:0] OFF_NMASK   = 8'h04;
    localparam logic [AW-1:0] OFF_JMASK   = 8'h08;
    localparam logic [AW-1:0] OFF_STAT    = 8'h0C;
    localparam logic [AW-1:0] OFF_PEND    = 8'h10;
    localparam logic [AW-1:0] OFF_EV_STAT = 8'h14;
    localparam logic [AW-1:0] OFF_EV_MASK = 8'h18;
    localparam logic [AW-1:0] OFF_RES     = 8'h40;

    // control register bits
    localparam int CTRL_SCAN   = 0;
    localparam int CTRL_NORMAL_CHAIN_RUNNING = 1;
    localparam int CTRL_INJECTED_CHAIN_RUNNING = 2;

    // status register bits
    localparam int STAT_NRUN = 0;
    localparam int STAT_JRUN = 1;
    localparam int STAT_CTU  = 2;
    localparam int STAT_ST   = 3;

    // event bits, same layout in status and mask
    localparam int EV_N = 0;
    localparam int EV_J = 1;
    localparam int EV_C = 2;
    localparam int EV_W = 3;

    // result word valid bit
    localparam int RES_VLD = 31;

    // kind of conversion in flight
    localparam logic [1:0] K_NORM = 2'h0;
    localparam logic [1:0] K_INJ  = 2'h1;
    localparam logic [1:0] K_CTU  = 2'h2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SAMP = 3'h2,
        ST_CONV = 3'h4
    } acp_state_t;
endpackage

// >>> tb/acp_ana_model.sv
// analogue sample and convert stage model, slower on higher channels
`timescale 1ns/1ps
module acp_ana_model (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // scheduler side
    input  wire logic        conv_start,
    input  wire logic        conv_abort,
    input  wire logic [2:0]  conv_ch,
    output logic             samp_done,
    output logic             conv_done,
    output logic [11:0]      conv_data
);
    logic [1:0] ph_ff;
    logic [5:0] cnt_ff;
    logic [2:0] ch_ff;
    always_ff @(posedge aclk) begin
        samp_done <= 1'h0;
        conv_done <= 1'h0;
        // off-duty data toggles so a stale word never passes for a result
        conv_data <= ~conv_data;
        if (!aresetn || conv_abort) begin
            ph_ff     <= 2'h0;
            conv_data <= 12'h000;
        end else if (conv_start) begin
            ph_ff  <= 2'h1;
            ch_ff  <= conv_ch;
            cnt_ff <= {conv_ch, 2'h2};
        end else if (ph_ff != 2'h0 && cnt_ff != 6'h00) begin
            cnt_ff <= cnt_ff - 6'h01;
        end else if (ph_ff == 2'h1) begin
            samp_done <= 1'h1;
            ph_ff     <= 2'h2;
            cnt_ff    <= {ch_ff, 2'h2};
        end else if (ph_ff == 2'h2) begin
            conv_done <= 1'h1;
            conv_data <= {9'h15a, ch_ff};
            ph_ff     <= 2'h0;
        end
    end
endmodule

// >>> tb/acp_chain_test.sv
// self-checking bench for the chain scheduler
`timescale 1ns/1ps
module acp_chain_test;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ctu_trig;
    logic        awready, wready, bvalid, arready, rvalid, conv_start, conv_abort;
    logic        samp_done, conv_done, irq;
    logic [7:0]  awaddr, araddr, nm;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic [2:0]  ctu_ch, conv_ch;
    logic [11:0] conv_data;
    int          fail_count, cmp_count, cyc, seed;
    acp_chain dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .ctu_trig(ctu_trig), .ctu_ch(ctu_ch), .conv_start(conv_start), .conv_abort(conv_abort),
        .conv_ch(conv_ch), .samp_done(samp_done), .conv_done(conv_done),
        .conv_data(conv_data), .irq(irq));
    acp_ana_model ana (.aclk(aclk), .aresetn(aresetn), .conv_start(conv_start),
        .conv_abort(conv_abort), .conv_ch(conv_ch), .samp_done(samp_done),
        .conv_done(conv_done), .conv_data(conv_data));
    initial begin
        aclk = 1'h0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // an edge passes first: no valid drops and rises in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        r = bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
        d = rdata;
        r = rresp;
    endtask
    task automatic wait_ev(input int b);
        d = 32'h0000_0000;
        for (int i = 0; i < 400 && !d[b]; i++) rd(acp_pkg::OFF_EV_STAT);
    endtask
    task automatic clr();
        wr(acp_pkg::OFF_PEND, 32'h0000_00ff);
        wr(acp_pkg::OFF_EV_STAT, 32'h0000_0007);
    endtask
    // channel held three cycles before the trigger edge and four after it
    task automatic trig(input logic [2:0] c);
        ctu_ch <= c;
        repeat (3) @(posedge aclk);
        ctu_trig <= 1'h1;
        repeat (4) @(posedge aclk);
        ctu_trig <= 1'h0;
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, ctu_trig} = 7'h00;
        {awaddr, araddr, wdata, ctu_ch, fail_count, cmp_count, cyc} = 0;
        wstrb = 4'hf;
        seed = 32'h0000_3369;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        rd(acp_pkg::OFF_STAT);
        chk(d, 32'h0000_0008);
        rd(8'h30);
        chk({30'h0, r}, {30'h0, acp_pkg::RESP_SLVERR});
        wr(acp_pkg::OFF_STAT, 32'hffff_ffff);
        chk({30'h0, r}, {30'h0, acp_pkg::RESP_SLVERR});
        $display("test reset and refusals done");
        nm = 8'($random(seed)) | 8'h01;
        wr(acp_pkg::OFF_EV_MASK, 32'h0000_0001);
        wr(acp_pkg::OFF_NMASK, {24'h0, nm});
        wr(acp_pkg::OFF_CTRL, 32'h0000_0002);
        wait_ev(acp_pkg::EV_N);
        chk({31'h0, irq}, 32'h0000_0001);
        rd(acp_pkg::OFF_PEND);
        chk(d, {24'h0, nm});
        chk({24'h0, nm & (nm ^ d[7:0])}, 32'h0000_0000);
        for (int c = 0; c < 8; c++) begin
            rd(acp_pkg::OFF_RES + 8'(4 * c));
            chk({19'h0, d[31], d[11:0]}, {19'h0, nm[c], nm[c] ? {9'h15a, 3'(c)} : 12'h0});
        end
        rd(acp_pkg::OFF_STAT);
        chk({31'h0, d[0]}, 32'h0000_0000);
        clr();
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0000_0000);
        $display("test one-shot chain done");
        wr(acp_pkg::OFF_NMASK, 32'h0000_000f);
        wr(acp_pkg::OFF_JMASK, 32'h0000_00f0);
        wr(acp_pkg::OFF_CTRL, 32'h0000_0002);
        wr(acp_pkg::OFF_CTRL, 32'h0000_0004);
        wait_ev(acp_pkg::EV_J);
        wait_ev(acp_pkg::EV_N);
        rd(acp_pkg::OFF_PEND);
        chk(d, 32'h0000_00ff);
        $display("test injected over normal done");
        for (int k = 0; k < 2; k++) begin
            clr();
            wr(k ? acp_pkg::OFF_JMASK : acp_pkg::OFF_NMASK, 32'h0000_001e);
            wr(acp_pkg::OFF_CTRL, k ? 32'h0000_0004 : 32'h0000_0002);
            trig(3'h7);
            wait_ev(k ? acp_pkg::EV_J : acp_pkg::EV_N);
            wait_ev(acp_pkg::EV_C);
            rd(acp_pkg::OFF_PEND);
            chk(d, 32'h0000_009e);
            $display("test trigger over chain %0d done", k);
        end
        // trigger on the last channel: m 0 while sampling, m 1 while converting
        for (int m = 0; m < 2; m++) begin
            clr();
            wr(acp_pkg::OFF_NMASK, 32'h0000_0081);
            wr(acp_pkg::OFF_CTRL, 32'h0000_0002);
            d = 32'h0000_0000;
            for (int i = 0; i < 200 && !(d[m ? 5 : 4] && conv_ch == 3'h7); i++) rd(acp_pkg::OFF_STAT);
            trig(3'h1);
            repeat (6) @(posedge aclk);
            rd(acp_pkg::OFF_EV_STAT);
            chk({31'h0, d[0]}, m ? 32'h0000_0000 : 32'h0000_0001);
            rd(acp_pkg::OFF_STAT);
            chk({31'h0, d[0]}, 32'h0000_0001);
            wr(acp_pkg::OFF_EV_STAT, 32'h0000_0007);
            wait_ev(acp_pkg::EV_N);
            rd(acp_pkg::OFF_PEND);
            chk(d, 32'h0000_0083);
            $display("test last channel abort %0d done", m);
        end
        summarize();
    end
endmodule
